// ===== core/slsp_pkg.sv
// Package of types and constants for the serial link sample packer
// Overview of operation
// - Mode 1 lane 0: A0, zeros, A1 top
// - Mode 2: one octet per lane, A-D
// - Mode 3: four 9+1 bit samples/lane
// - Mode 4: three lanes, 12-bit split stream
// - Mode 5: two lanes, two octets each
// - Mode 6 packs exactly like mode 1
// - Mode 7: one octet per lane, A-D
// - Mode 8: two 9+3 bit samples/lane
// - Mode 9: eight lanes, two samples/channel
// - Mode 10: even lower lane, odd upper
// - MSB first, extra low bits zero
// - All tail bits driven zero
// - Lowest lanes used, upper ones powered down
package slsp_pkg;

   localparam int SLSP_CH        = 4;
   localparam int SLSP_LANES     = 8;
   localparam int SLSP_SW        = 9;
   localparam int SLSP_LANE_W    = 40;
   localparam int SLSP_MAX_SPC   = 8;
   localparam int SLSP_FIFO_D    = 16;

   localparam logic [3:0] SLSP_M1  = 4'h1;
   localparam logic [3:0] SLSP_M2  = 4'h2;
   localparam logic [3:0] SLSP_M3  = 4'h3;
   localparam logic [3:0] SLSP_M4  = 4'h4;
   localparam logic [3:0] SLSP_M5  = 4'h5;
   localparam logic [3:0] SLSP_M6  = 4'h6;
   localparam logic [3:0] SLSP_M7  = 4'h7;
   localparam logic [3:0] SLSP_M8  = 4'h8;
   localparam logic [3:0] SLSP_M9  = 4'h9;
   localparam logic [3:0] SLSP_M10 = 4'hA;

   typedef logic [SLSP_SW-1:0]     slsp_s_t;
   typedef logic [SLSP_LANE_W-1:0] slsp_lane_t;

   typedef struct packed {
      slsp_s_t [SLSP_CH-1:0] ch;
   } slsp_smp_t;

   typedef struct packed {
      slsp_lane_t [SLSP_LANES-1:0] lane;
   } slsp_frm_t;

   typedef struct packed {
      logic       ok;
      logic [3:0] lanes;
      logic [2:0] octets;
      logic [3:0] spc;
   } slsp_cfg_t;

   // Lanes, octets per lane and samples per channel for each mode
   function automatic slsp_cfg_t slsp_cfg(input logic [3:0] m);
      slsp_cfg_t c;
      c = '{ok: 1'b1, lanes: 4'h0, octets: 3'h0, spc: 4'h1};
      case (m)
         SLSP_M1, SLSP_M6: c = '{1'b1, 4'h6, 3'h2, 4'h2};
         SLSP_M2, SLSP_M7: c = '{1'b1, 4'h4, 3'h1, 4'h1};
         SLSP_M3:          c = '{1'b1, 4'h4, 3'h5, 4'h4};
         SLSP_M4:          c = '{1'b1, 4'h3, 3'h2, 4'h1};
         SLSP_M5:          c = '{1'b1, 4'h2, 3'h2, 4'h1};
         SLSP_M8:          c = '{1'b1, 4'h4, 3'h3, 4'h2};
         SLSP_M9:          c = '{1'b1, 4'h8, 3'h1, 4'h2};
         SLSP_M10:         c = '{1'b1, 4'h8, 3'h5, 4'h8};
         default:          c = '{1'b0, 4'h0, 3'h0, 4'h1};
      endcase
      return c;
   endfunction : slsp_cfg

endpackage : slsp_pkg

// ===== core/slsp_fifo.sv
// Sample FIFO with registered read data
`timescale 1ns/1ps
module slsp_fifo #(
   parameter int W = 36,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         clock_i,
   input  wire logic         nrst_i,
   // Write side
   input  wire logic         wr_valid_i,
   output wire logic         wr_ready_o,
   input  wire logic [W-1:0] wr_data_i,
   // Read side
   output wire logic         rd_valid_o,
   input  wire logic         rd_ready_i,
   output wire logic [W-1:0] rd_data_o
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          ov_r;
   logic [W-1:0]  od_r;

   wire full  = (cnt_r == (AW+1)'(D));
   wire empty = (cnt_r == '0);
   wire push  = wr_valid_i && !full;
   // Output stage refills when drained or empty
   wire pop   = !empty && (!ov_r || rd_ready_i);

   assign wr_ready_o = !full;
   assign rd_valid_o = ov_r;
   assign rd_data_o  = od_r;

   always_ff @(posedge clock_i)
   begin
      if (push)
         mem[wp_r] <= wr_data_i;
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         ov_r  <= 1'b0;
         od_r  <= '0;
      end
      else
      begin
         if (push)
            wp_r <= wp_r + 1'b1;
         if (pop)
         begin
            rp_r <= rp_r + 1'b1;
            od_r <= mem[rp_r];
         end
         if (pop)
            ov_r <= 1'b1;
         else if (rd_ready_i)
            ov_r <= 1'b0;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : slsp_fifo

// ===== core/slsp_packer.sv
// Transport-layer sample packer: samples in, lane frames out
`timescale 1ns/1ps
module slsp_packer (
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                nrst_i,
   // Static configuration
   input  wire logic [3:0]          transport_mode_select_i,
   output wire logic                mode_ok_o,
   // Sample input, one sample per channel
   input  wire logic                in_valid_i,
   output wire logic                in_ready_o,
   input  wire slsp_pkg::slsp_smp_t in_smp_i,
   // Frame output
   output wire logic                frame_valid_o,
   input  wire logic                frame_ready_i,
   output wire slsp_pkg::slsp_frm_t frame_o,
   output wire logic [2:0]          octets_o,
   output wire logic [7:0]          lane_en_o
);
   import slsp_pkg::*;

   typedef enum logic {SLSP_COLLECT, SLSP_EMIT} slsp_st_t;

   // MSB first, pad bits low
   // Sample padded with one or three zero low bits
   function automatic logic [9:0] pad1(input slsp_s_t s);
      return {s, 1'b0};
   endfunction : pad1

   function automatic logic [11:0] pad3(input slsp_s_t s);
      return {s, 3'h0};
   endfunction : pad3

   // 8-bit transport keeps the top bits, left-justified octet
   function automatic slsp_lane_t oct(input slsp_s_t s);
      return {s[8:1], 32'h0};
   endfunction : oct

   // Four 9+1 bit samples fill five octets
   function automatic slsp_lane_t quad(input slsp_s_t a,
                                       input slsp_s_t b,
                                       input slsp_s_t c,
                                       input slsp_s_t d);
      return {pad1(a), pad1(b), pad1(c), pad1(d)};
   endfunction : quad

   // Four 12-bit padded samples as one 48-bit stream
   function automatic logic [47:0] trip(input slsp_s_t a,
                                        input slsp_s_t b,
                                        input slsp_s_t c,
                                        input slsp_s_t d);
      return {pad3(a), pad3(b), pad3(c), pad3(d)};
   endfunction : trip

   slsp_st_t                     st_r;
   slsp_st_t                     st_nxt;
   logic [3:0]                   idx_r;
   slsp_s_t [SLSP_CH-1:0][SLSP_MAX_SPC-1:0] smp_r;
   slsp_s_t [SLSP_CH-1:0][SLSP_MAX_SPC-1:0] smp_nxt;
   slsp_frm_t                    frm_r;
   slsp_cfg_t                    cfg;
   logic                         f_valid;
   logic                         f_ready;
   slsp_smp_t                    f_data;
   logic [47:0]                  t_ab;
   logic [47:0]                  t_cd;
   logic [47:0]                  t_m4;
   slsp_lane_t [SLSP_LANES-1:0]  f1;
   slsp_lane_t [SLSP_LANES-1:0]  f2;
   slsp_lane_t [SLSP_LANES-1:0]  f3;
   slsp_lane_t [SLSP_LANES-1:0]  f4;
   slsp_lane_t [SLSP_LANES-1:0]  f5;
   slsp_lane_t [SLSP_LANES-1:0]  f8;
   slsp_lane_t [SLSP_LANES-1:0]  f9;
   slsp_lane_t [SLSP_LANES-1:0]  f10;
   slsp_lane_t [SLSP_LANES-1:0]  fsel;
   logic [7:0]                   en_mask;

   // Back-pressure from the frame port reaches the source via the FIFO
   slsp_fifo #(
      .W ($bits(slsp_smp_t)),
      .D (SLSP_FIFO_D)
   ) u_fifo (
      .clock_i    (clock_i),
      .nrst_i     (nrst_i),
      .wr_valid_i (in_valid_i),
      .wr_ready_o (in_ready_o),
      .wr_data_i  (in_smp_i),
      .rd_valid_o (f_valid),
      .rd_ready_i (f_ready),
      .rd_data_o  (f_data)
   );

   assign cfg       = slsp_cfg(transport_mode_select_i);
   assign mode_ok_o = cfg.ok;
   assign octets_o  = cfg.octets;
   assign en_mask   = 8'(9'h0FF >> (4'h8 - cfg.lanes));
   assign lane_en_o = en_mask;

   // Unsupported modes never pop, so no sample is lost
   assign f_ready = (st_r == SLSP_COLLECT) && cfg.ok;
   wire take      = f_ready && f_valid;
   wire last      = (idx_r == cfg.spc - 4'h1);

   // Layouts see the sample taken this cycle, else the last one is lost
   always_comb
   begin
      smp_nxt = smp_r;
      if (take)
         for (int c = 0; c < SLSP_CH; c++)
            smp_nxt[c][idx_r[2:0]] = f_data.ch[c];
   end

   // split streams for modes 1 and 6
   assign t_ab = trip(smp_nxt[0][0], smp_nxt[0][1],
                      smp_nxt[1][0], smp_nxt[1][1]);
   assign t_cd = trip(smp_nxt[2][0], smp_nxt[2][1],
                      smp_nxt[3][0], smp_nxt[3][1]);
   // one sample per channel over three lanes
   assign t_m4 = trip(smp_nxt[0][0], smp_nxt[1][0],
                      smp_nxt[2][0], smp_nxt[3][0]);

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_trip
         assign f1[g]   = {t_ab[47-16*g -: 16], 24'h0};
         assign f1[g+3] = {t_cd[47-16*g -: 16], 24'h0};
         assign f4[g]   = {t_m4[47-16*g -: 16], 24'h0};
      end
      for (g = 0; g < SLSP_CH; g++)
      begin : g_ch
         assign f2[g]     = oct(smp_nxt[g][0]);
         assign f2[g+4]   = '0;
         assign f3[g]     = quad(smp_nxt[g][0], smp_nxt[g][1],
                                 smp_nxt[g][2], smp_nxt[g][3]);
         assign f3[g+4]   = '0;
         // two samples, three pad bits each
         assign f8[g]     = {pad3(smp_nxt[g][0]), pad3(smp_nxt[g][1]),
                             16'h0};
         assign f8[g+4]   = '0;
         assign f9[2*g]   = oct(smp_nxt[g][0]);
         assign f9[2*g+1] = oct(smp_nxt[g][1]);
         // even samples low lane, odd high
         assign f10[2*g]   = quad(smp_nxt[g][0], smp_nxt[g][2],
                                  smp_nxt[g][4], smp_nxt[g][6]);
         assign f10[2*g+1] = quad(smp_nxt[g][1], smp_nxt[g][3],
                                  smp_nxt[g][5], smp_nxt[g][7]);
      end
   endgenerate

   assign f1[7:6] = '0;
   assign f4[7:3] = '0;
   assign f5[0]   = {smp_nxt[0][0][8:1], smp_nxt[1][0][8:1], 24'h0};
   assign f5[1]   = {smp_nxt[2][0][8:1], smp_nxt[3][0][8:1], 24'h0};
   assign f5[7:2] = '0;

   // mode 6 reuses mode 1, mode 7 reuses mode 2
   wire m1  = (transport_mode_select_i == SLSP_M1) ||
              (transport_mode_select_i == SLSP_M6);
   wire m2  = (transport_mode_select_i == SLSP_M2) ||
              (transport_mode_select_i == SLSP_M7);
   wire m3  = (transport_mode_select_i == SLSP_M3);
   wire m4  = (transport_mode_select_i == SLSP_M4);
   wire m5  = (transport_mode_select_i == SLSP_M5);
   wire m8  = (transport_mode_select_i == SLSP_M8);
   wire m9  = (transport_mode_select_i == SLSP_M9);
   wire m10 = (transport_mode_select_i == SLSP_M10);

   assign fsel = m1 ? f1 : m2 ? f2 : m3 ? f3 : m4 ? f4 : m5 ? f5 :
                 m8 ? f8 : m9 ? f9 : m10 ? f10 : '0;

   assign st_nxt = (st_r == SLSP_COLLECT) ?
                   ((take && last) ? SLSP_EMIT : SLSP_COLLECT) :
                   (frame_ready_i ? SLSP_COLLECT : SLSP_EMIT);

   assign frame_valid_o = (st_r == SLSP_EMIT);
   assign frame_o       = frm_r;

   // Samples are stored per channel at the frame's sample index
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         smp_r <= '0;
      else if (take)
         for (int c = 0; c < SLSP_CH; c++)
            smp_r[c][idx_r[2:0]] <= f_data.ch[c];
   end

   // cfg.spc transfers per frame, index restarts each frame
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_r  <= SLSP_COLLECT;
         idx_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         if (take)
            idx_r <= last ? 4'h0 : idx_r + 4'h1;
      end
   end

   // Frame register loads while collecting, holds during emit
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         frm_r <= '0;
      else if (st_r == SLSP_COLLECT)
         frm_r.lane <= fsel;
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);

   mode1_lane0_a: assert property (
      frame_valid_o && m1 |-> frame_o.lane[0][39:24] ==
         {smp_r[0][0], 3'h0, smp_r[0][1][8:5]})
      else $error("mode 1 lane 0 mismatch");

   mode1_lane2_a: assert property (
      frame_valid_o && m1 |-> frame_o.lane[2] ==
         {smp_r[1][0][0], 3'h0, smp_r[1][1], 3'h0, 24'h0})
      else $error("mode 1 lane 2 mismatch");

   // mode 2 lane 3 carries D0
   mode2_octet_a: assert property (
      frame_valid_o && m2 |-> frame_o.lane[3][39:32] == smp_r[3][0][8:1])
      else $error("mode 2 lane 3 mismatch");

   // mode 3 lane 1 is channel B
   mode3_quad_a: assert property (
      frame_valid_o && m3 |-> frame_o.lane[1] ==
         {smp_r[1][0], 1'b0, smp_r[1][1], 1'b0,
          smp_r[1][2], 1'b0, smp_r[1][3], 1'b0})
      else $error("mode 3 lane 1 mismatch");

   mode4_split_a: assert property (
      frame_valid_o && m4 |-> frame_o.lane[1][39:24] ==
         {smp_r[1][0][4:0], 3'h0, smp_r[2][0][8:1]})
      else $error("mode 4 lane 1 mismatch");

   mode8_pad_a: assert property (
      frame_valid_o && m8 |-> frame_o.lane[0][30:28] == 3'h0 &&
         frame_o.lane[0][18:0] == 19'h0)
      else $error("mode 8 padding not zero");

   // mode 10 odd samples on upper lane
   mode10_odd_a: assert property (
      frame_valid_o && m10 |-> frame_o.lane[7][39:31] == smp_r[3][1] &&
         frame_o.lane[7][29:21] == smp_r[3][3])
      else $error("mode 10 odd lane mismatch");

   idle_lanes_a: assert property (
      frame_valid_o |-> (frame_o.lane[7] == '0 || lane_en_o[7]) &&
         (frame_o.lane[3] == '0 || lane_en_o[3]))
      else $error("disabled lane not zero");

   frame_hold_a: assert property (
      frame_valid_o && !frame_ready_i |=> frame_valid_o &&
         $stable(frame_o))
      else $error("frame changed before accept");

   // emit follows the last sample of the frame
   frame_after_a: assert property (
      take && last |=> frame_valid_o ##0 !f_ready)
      else $error("frame not emitted after last sample");

   mode5_pair_a: assert property (
      frame_valid_o && m5 |-> frame_o.lane[1] ==
         {smp_r[2][0][8:1], smp_r[3][0][8:1], 24'h0})
      else $error("mode 5 lane 1 mismatch");

   mode9_pair_a: assert property (
      frame_valid_o && m9 |-> frame_o.lane[3][39:32] == smp_r[1][1][8:1])
      else $error("mode 9 lane 3 mismatch");

   mode1_tail_a: assert property (
      frame_valid_o && m1 |-> frame_o.lane[5][23:0] == 24'h0 &&
         frame_o.lane[6] == '0 && frame_o.lane[7] == '0)
      else $error("mode 1 tail not zero");

   frame_drop_a: assert property (
      frame_valid_o && frame_ready_i |=> !frame_valid_o)
      else $error("frame valid held after accept");

endmodule : slsp_packer

// ===== dv/slsp_rx.sv
// Receiver model taking lane frames from the packer
`timescale 1ns/1ps
module slsp_rx (
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                nrst_i,
   // Pace control from the bench
   input  wire logic                stall_i,
   input  wire logic                slow_i,
   // Frame side
   input  wire slsp_pkg::slsp_frm_t frame_i,
   input  wire logic                frame_valid_i,
   output wire logic                frame_ready_o,
   input  wire logic [7:0]          lane_en_i,
   // Count of faults seen on the frame side
   output wire logic [7:0]          err_o
);
   import slsp_pkg::*;
   logic      ready_r;
   logic      wait_r;
   logic [7:0] err_r;
   slsp_frm_t hold_r;
   slsp_frm_t q[$];

   assign frame_ready_o = ready_r;
   assign err_o         = err_r;

   // Slow pace accepts on every other edge only
   always @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ready_r <= 1'b0;
         wait_r  <= 1'b0;
         err_r   <= 8'h00;
      end
      else
      begin
         ready_r <= !stall_i && (!slow_i || !ready_r);
         wait_r  <= frame_valid_i && !ready_r;
         hold_r  <= frame_i;
         if (wait_r && frame_valid_i && frame_i !== hold_r)
            err_r <= err_r + 8'h01;
         if (frame_valid_i && ready_r)
         begin
            q.push_back(frame_i);
            for (int l = 0; l < 8; l++)
               if (!lane_en_i[l] && frame_i.lane[l] !== 40'h0)
                  err_r <= err_r + 8'h01;
         end
      end
   end
endmodule : slsp_rx

// ===== dv/slsp_packer_test.sv
// Self-checking bench for the sample packer
`timescale 1ns/1ps
`define chk(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
   bad_count++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module slsp_packer_test;
   import slsp_pkg::*;
   // Lanes, octets, words per frame and field width by mode
   localparam int LN[11] = '{0, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8};
   localparam int OC[11] = '{0, 2, 1, 5, 2, 2, 2, 1, 3, 1, 5};
   localparam int SP[11] = '{0, 2, 1, 4, 1, 1, 2, 1, 2, 2, 8};
   localparam int FW[11] = '{0, 12, 8, 10, 12, 8, 12, 8, 12, 8, 10};
   logic       clock_i, nrst, stall, slow, in_valid, in_ready;
   logic       mode_ok, frame_valid, frame_ready;
   logic [3:0] mode;
   logic [2:0] octets;
   logic [7:0] lane_en, rx_err;
   slsp_smp_t  in_smp;
   slsp_frm_t  frame;
   int         tests_run, bad_count;

   slsp_packer i_dut (.clock_i(clock_i), .nrst_i(nrst),
      .transport_mode_select_i(mode), .mode_ok_o(mode_ok),
      .in_valid_i(in_valid), .in_ready_o(in_ready), .in_smp_i(in_smp),
      .frame_valid_o(frame_valid), .frame_ready_i(frame_ready),
      .frame_o(frame), .octets_o(octets), .lane_en_o(lane_en));
   slsp_rx i_rx (.clock_i(clock_i), .nrst_i(nrst), .stall_i(stall),
      .slow_i(slow), .frame_i(frame), .frame_valid_i(frame_valid),
      .frame_ready_o(frame_ready), .lane_en_i(lane_en), .err_o(rx_err));

   initial
   begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   function automatic logic [8:0] sv(input int i, input int c);
      return 9'((i * 4 + c) * 53 + 165);
   endfunction : sv

   function automatic slsp_smp_t wd(input int i);
      slsp_smp_t w;
      for (int c = 0; c < 4; c++)
         w.ch[c] = sv(i, c);
      return w;
   endfunction : wd

   // Fields run channel-major across lanes, MSB first, zero padded
   function automatic slsp_frm_t expf(input int m, input int b);
      logic [319:0] st;
      logic [8:0]   v;
      slsp_frm_t    f;
      int           p, k, ll;
      st = '0;
      f  = '0;
      p  = 0;
      ll = OC[m] * 8;
      for (int c = 0; c < 4; c++)
         for (int j = 0; j < SP[m]; j++)
         begin
            k = (m == 10) ? ((j < 4) ? 2 * j : 2 * j - 7) : j;
            v = sv(b + k, c);
            for (int x = 0; x < FW[m]; x++)
            begin
               st[319 - p] = (x < 9) ? v[8 - x] : 1'b0;
               p++;
            end
         end
      for (int l = 0; l < LN[m]; l++)
         for (int x = 0; x < ll; x++)
            f.lane[l][39 - x] = st[319 - l * ll - x];
      return f;
   endfunction : expf

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   task automatic tmo(input string nm);
      bad_count++;
      $display("mismatch %s exp done got timeout", nm);
      wrap_up();
   endtask : tmo

   task automatic send(input int n, input int b);
      int t;
      for (int i = 0; i < n; i++)
      begin
         @(negedge clock_i);
         in_valid = 1'b1;
         in_smp   = wd(b + i);
         t = 0;
         while (in_ready !== 1'b1 && t < 100)
         begin
            @(negedge clock_i);
            t++;
         end
         if (t == 100)
            tmo("in_ready");
         @(posedge clock_i);
      end
      @(negedge clock_i);
      in_valid = 1'b0;
   endtask : send

   task automatic got(input int n);
      int t;
      t = 0;
      while (i_rx.q.size() < n && t < 400)
      begin
         @(posedge clock_i);
         t++;
      end
      if (t == 400)
         tmo("frames");
   endtask : got

   task automatic do_reset();
      nrst = 1'b0;
      repeat (8) @(negedge clock_i);
      `chk("rst ready", 1'b1, in_ready)
      `chk("rst valid", 1'b0, frame_valid)
      `chk("rst frame", slsp_frm_t'(0), frame)
      nrst = 1'b1;
   endtask : do_reset

   task automatic t_mode(input int m);
      slsp_frm_t want;
      slsp_frm_t seen;
      @(negedge clock_i);
      mode = 4'(m);
      slow = (m % 2 == 1);
      i_rx.q.delete();
      @(negedge clock_i);
      `chk("mode ok", 1'b1, mode_ok)
      `chk("octets", 3'(OC[m]), octets)
      `chk("lane en", 8'((1 << LN[m]) - 1), lane_en)
      send(2 * SP[m], 16 * m);
      got(2);
      for (int f = 0; f < 2; f++)
      begin
         want = expf(m, 16 * m + f * SP[m]);
         seen = i_rx.q[f];
         `chk("lo", want.lane[2:0], seen.lane[2:0])
         `chk("mid", want.lane[5:3], seen.lane[5:3])
         `chk("hi", want.lane[7:6], seen.lane[7:6])
      end
      $display("test mode %0d done", m);
   endtask : t_mode

   // Stalled receiver lets the buffer fill, then it drains in order
   task automatic t_fill();
      int k;
      k = 0;
      @(negedge clock_i);
      mode  = SLSP_M2;
      slow  = 1'b0;
      stall = 1'b1;
      i_rx.q.delete();
      in_valid = 1'b1;
      in_smp   = wd(k);
      while (in_ready === 1'b1 && k < 40)
      begin
         @(posedge clock_i);
         k++;
         @(negedge clock_i);
         in_smp = wd(k);
      end
      in_valid = 1'b0;
      `chk("refused", 1'b1, k >= SLSP_FIFO_D && k <= SLSP_FIFO_D + 4)
      stall = 1'b0;
      got(k);
      for (int i = 0; i < k; i++)
         `chk("drain", expf(2, i), i_rx.q[i])
      `chk("drained ready", 1'b1, in_ready)
      $display("test fill done");
   endtask : t_fill

   task automatic t_bad();
      for (int m = 11; m <= 16; m++)
      begin
         @(negedge clock_i);
         mode = 4'(m);
         @(negedge clock_i);
         `chk("bad ok", 1'b0, mode_ok)
         `chk("bad lanes", 8'h00, lane_en)
      end
      i_rx.q.delete();
      send(1, 0);
      repeat (20) @(posedge clock_i);
      `chk("bad frames", 0, i_rx.q.size())
      `chk("rx faults early", 8'h00, rx_err)
      @(negedge clock_i);
      do_reset();
      $display("test bad mode done");
   endtask : t_bad

   initial
   begin
      tests_run = 0;
      bad_count = 0;
      nrst      = 1'b0;
      stall     = 1'b0;
      slow      = 1'b0;
      in_valid  = 1'b0;
      in_smp    = '0;
      mode      = SLSP_M1;
      do_reset();
      for (int m = 1; m <= 10; m++)
         t_mode(m);
      t_fill();
      t_bad();
      t_mode(4);
      `chk("rx faults", 8'h00, rx_err)
      wrap_up();
   end
endmodule : slsp_packer_test
